//--- temp_seq_regs.vh
// Constants of the temperature sequencer and event-timing controller.
// Assumes a 10 MHz core clock; times below are given in us or ms and scaled to core clock cycles.
//
// Function
// - Port-select field picks which temperature ports run and their order.
// - Select 11b gives one evaluation and one real run on all four ports.
// - Zero to seven dummy preamble runs go through the emulation resistor first.
// - Each selected port gets a coarse evaluation run before its real run.
// - Port-cycle field sets spacing between starts of successive port runs.
// - Charge pin charges the capacitor; each port is timed by its RC discharge.
// - At the end, results are written and temp-done flag set; interrupt raised if per-command bit set or sequence ends.
// - A time below 8 us writes 0000h as a shorted probe.
// - No discharge within 2 us past the interval: FFFFh, timeout flag, interrupt.
// - Any other temperature failure writes FFFFh to every port result.
// - Three automatic commands: repeat difference, repeat temperature, repeat both.
// - Continuous bit restarts the sequence until halt; else one sequence only.
// - Per-command bit set: interrupt per command; clear: only at sequence end and on a discharge timeout.
// - Errors never stop an automatic sequence; each is handled as usual.
// - Calibration runs inside automatic sequences when its configuration asks.
// - Only error-free flight measurements advance the flight cycle counter.
// - Spread register holds maximum minus minimum of valid flight results.
// - Temperature cycle counter advances after each error-free temperature run.
// - Failed temperature runs are kept out of the temperature averages.
// - Each error-free flight cycle writes upstream minus downstream and updates its average.
// - Rate multiplier, rate field and count field set flight rate and count.
// - After the difference average updates at sequence end: flag and interrupt.
// - Interrupt stays asserted until the host reads the interrupt status.
`ifndef TEMP_SEQ_REGS_VH
`define TEMP_SEQ_REGS_VH

`define MCLK_MHZ 10
// Capacitor charge time before each discharge
`define CHARGE_US 4
`define CHARGE_CYC (`CHARGE_US * `MCLK_MHZ)
`define SHORT_US 8
`define SHORT_CYC (`SHORT_US * `MCLK_MHZ)
`define OPEN_US 2
`define OPEN_CYC (`OPEN_US * `MCLK_MHZ)
// Port-cycle interval choices
`define PORT_CYC0_US 128
`define PORT_CYC1_US 256
`define PORT_CYC2_US 384
`define PORT_CYC3_US 512
`define PORT_CYC0 (`PORT_CYC0_US * `MCLK_MHZ)
`define PORT_CYC1 (`PORT_CYC1_US * `MCLK_MHZ)
`define PORT_CYC2 (`PORT_CYC2_US * `MCLK_MHZ)
`define PORT_CYC3 (`PORT_CYC3_US * `MCLK_MHZ)
// Base repetition period of automatic commands
`define RATE_BASE_MS 500
`define RATE_BASE_CYC (`RATE_BASE_MS * `MCLK_MHZ * 1000)
// Result codes
`define RES_SHORT 16'h0000
`define RES_OPEN 16'hffff
`define DIFF_ERR 32'h7fffffff
// Calibration configuration bits
`define CAL_TOF_BIT 0
`define CAL_TEMP_BIT 1

`endif

//--- pin_filter.v
// Three-stage input synchroniser for a pin from outside the clock domain.
// Output changes only when the second and third stages agree.
`timescale 1ns/1ns
module pin_filter (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Pin and filtered level
    input wire pin,
    output reg level
);

reg s1;
reg s2;
reg s3;

always @(posedge mclk) begin
    if (rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        level <= 1'b0;
    end else begin
        s1 <= pin;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
            level <= s3;
        end
    end
end

endmodule

//--- temp_sequencer.v
// Temperature port sequencer and event-timing controller.
// The flight-time engine and calibrator sit outside and answer start pulses;
// the temperature comparator arrives as an asynchronous pin.
`timescale 1ns/1ns
`include "temp_seq_regs.vh"
module temp_sequencer #(
    parameter [31:0] RATE_BASE_CYCLES = `RATE_BASE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Commands, one-cycle pulses
    input wire auto_tof_cmd,
    input wire auto_temp_cmd,
    input wire auto_both_cmd,
    input wire halt_cmd,
    input wire irq_status_read,
    // Configuration
    input wire [1:0] port_select,
    input wire [2:0] dummy_cycle_count,
    input wire [1:0] port_cycle_interval,
    input wire continuous_sequence,
    input wire per_command_irq,
    input wire irq_enable,
    input wire rate_multiplier,
    input wire [3:0] diff_rate_field,
    input wire [4:0] diff_count_field,
    input wire [3:0] temp_rate_field,
    input wire [4:0] temp_count_field,
    input wire [1:0] cal_config,
    // Temperature front end
    input wire temp_comparator,
    output reg cap_charge_pin,
    output reg [3:0] port_enable,
    output reg emul_enable,
    // Flight-time engine and calibrator
    output reg tof_start,
    input wire tof_done,
    input wire tof_error,
    input wire [31:0] upstream_average,
    input wire [31:0] downstream_average,
    output reg cal_start,
    input wire cal_done,
    // Results
    output wire [63:0] port_time_integer,
    output wire [63:0] port_time_fraction,
    output wire [63:0] temp_average_result,
    output reg [31:0] flight_difference,
    output reg [31:0] difference_running_average,
    output reg [31:0] tof_spread,
    output reg [7:0] tof_valid_counter,
    output reg [7:0] temp_cycle_counter,
    // Status and interrupt
    output reg temp_done_flag,
    output reg timeout_flag,
    output reg tof_sequence_done_flag,
    output reg temp_seq_done_flag,
    output reg sequence_running,
    output reg irq_n,
    output reg irq_drive_n
);

localparam S_IDLE = 3'd0;
localparam S_CAL = 3'd1;
localparam S_TOF = 3'd2;
localparam S_CHG = 3'd3;
localparam S_DIS = 3'd4;
localparam S_GAP = 3'd5;
localparam S_TFIN = 3'd6;
localparam [12:0] CHG = `CHARGE_CYC;
////////////////////////////////////////

wire comp_high;

pin_filter comp_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(temp_comparator),
    .level(comp_high)
);

reg [2:0] state;
reg [1:0] mode;
reg cal_for_temp;
reg [31:0] tof_tmr;
reg [31:0] temp_tmr;
reg [5:0] tof_left;
reg [5:0] temp_left;
reg tof_pend;
reg temp_pend;
reg [3:0] step;
reg [12:0] tcnt;
reg t_err;
reg t_fault;
reg tfin;
reg t_bad;
reg ev_irq;
reg irq_pending;
reg [15:0] pend [0:3];
reg signed [31:0] tof_min;
reg signed [31:0] tof_max;

// Port order for each port-select setting
function [1:0] port_at;
    input [1:0] sel;
    input [1:0] k;
    begin
        case (sel)
            2'b00: port_at = k;
            2'b01: port_at = k + 2'd2;
            2'b10: port_at = {k[0], k[1]};
            default: port_at = k;
        endcase
    end
endfunction

////////////////////////////////////////

reg [31:0] ivl;
always @* begin
    case (port_cycle_interval)
        2'b00: ivl = `PORT_CYC0;
        2'b01: ivl = `PORT_CYC1;
        2'b10: ivl = `PORT_CYC2;
        default: ivl = `PORT_CYC3;
    endcase
end

wire [31:0] base = rate_multiplier ? (RATE_BASE_CYCLES >> 3) : RATE_BASE_CYCLES;
wire [63:0] tof_prod = ({28'h0, diff_rate_field} + 32'h1) * base;
wire [63:0] temp_prod = ({28'h0, temp_rate_field} + 32'h1) * base;
wire [31:0] tof_period = tof_prod[31:0];
wire [31:0] temp_period = temp_prod[31:0];

wire dummy_step = step < {1'b0, dummy_cycle_count};
wire [3:0] k = step - {1'b0, dummy_cycle_count};
wire real_step = !dummy_step && k[0];
wire [1:0] pidx = port_at(port_select, k[2:1]);
wire [3:0] last_step = {1'b0, dummy_cycle_count} + (port_select[1] ? 4'd8 : 4'd4) - 4'd1;
wire [12:0] meas = tcnt - CHG;
wire in_temp = state == S_CHG || state == S_DIS || state == S_GAP;

wire signed [31:0] diff = upstream_average - downstream_average;
wire signed [32:0] avg_d = {diff[31], diff} - {difference_running_average[31],
    difference_running_average};
wire signed [32:0] avg_n = {25'h0, tof_valid_counter} + 33'h1;
wire signed [32:0] avg_q = avg_d / avg_n;
wire first_valid = tof_valid_counter == 8'h0;
wire signed [31:0] new_min = (first_valid || diff < tof_min) ? diff : tof_min;
wire signed [31:0] new_max = (first_valid || diff > tof_max) ? diff : tof_max;
wire start_cmd = auto_tof_cmd | auto_temp_cmd | auto_both_cmd;
wire [1:0] start_mode = {auto_temp_cmd | auto_both_cmd, auto_tof_cmd | auto_both_cmd};

// Clears per-sequence state except the port temperature averages; bit 0 of run is flight, bit 1 temperature
task init_seq;
    input [1:0] run;
    begin
        tof_left <= run[0] ? {1'b0, diff_count_field} + 6'd1 : 6'd0;
        temp_left <= run[1] ? {1'b0, temp_count_field} + 6'd1 : 6'd0;
        tof_pend <= 1'b0;
        temp_pend <= 1'b0;
        tof_tmr <= 32'h0;
        temp_tmr <= 32'h0;
        tof_valid_counter <= 8'h0;
        temp_cycle_counter <= 8'h0;
        difference_running_average <= 32'h0;
        tof_spread <= 32'h0;
    end
endtask

////////////////////////////////////////

always @(posedge mclk) begin
    if (rst) begin
        state <= S_IDLE;
        mode <= 2'b00;
        cal_for_temp <= 1'b0;
        tof_tmr <= 32'h0;
        temp_tmr <= 32'h0;
        tof_left <= 6'h0;
        temp_left <= 6'h0;
        tof_pend <= 1'b0;
        temp_pend <= 1'b0;
        step <= 4'h0;
        tcnt <= 13'h0;
        t_err <= 1'b0;
        t_fault <= 1'b0;
        tfin <= 1'b0;
        t_bad <= 1'b0;
        ev_irq <= 1'b0;
        tof_min <= 32'h0;
        tof_max <= 32'h0;
        cap_charge_pin <= 1'b0;
        port_enable <= 4'h0;
        emul_enable <= 1'b0;
        tof_start <= 1'b0;
        cal_start <= 1'b0;
        flight_difference <= 32'h0;
        difference_running_average <= 32'h0;
        tof_spread <= 32'h0;
        tof_valid_counter <= 8'h0;
        temp_cycle_counter <= 8'h0;
        temp_done_flag <= 1'b0;
        timeout_flag <= 1'b0;
        tof_sequence_done_flag <= 1'b0;
        temp_seq_done_flag <= 1'b0;
        sequence_running <= 1'b0;
        pend[0] <= 16'h0;
        pend[1] <= 16'h0;
        pend[2] <= 16'h0;
        pend[3] <= 16'h0;
    end else begin
        tof_start <= 1'b0;
        cal_start <= 1'b0;
        ev_irq <= 1'b0;
        tfin <= 1'b0;
        // Status read first, so an event in the same cycle still sets its flag
        if (irq_status_read) begin
            temp_done_flag <= 1'b0;
            timeout_flag <= 1'b0;
            tof_sequence_done_flag <= 1'b0;
            temp_seq_done_flag <= 1'b0;
        end
        port_enable <= (in_temp && !dummy_step) ? (4'h1 << pidx) : 4'h0;
        emul_enable <= in_temp && dummy_step;
        if (tof_tmr != 32'h0) begin
            tof_tmr <= tof_tmr - 32'h1;
        end
        if (temp_tmr != 32'h0) begin
            temp_tmr <= temp_tmr - 32'h1;
        end
        if (tof_tmr == 32'h0 && tof_left != 6'h0) begin
            tof_pend <= 1'b1;
        end
        if (temp_tmr == 32'h0 && temp_left != 6'h0) begin
            temp_pend <= 1'b1;
        end
        if (start_cmd) begin
            mode <= start_mode;
            sequence_running <= 1'b1;
            init_seq(start_mode);
            state <= S_IDLE;
            cap_charge_pin <= 1'b0;
        end else if (halt_cmd) begin
            sequence_running <= 1'b0;
            tof_left <= 6'h0;
            temp_left <= 6'h0;
            tof_pend <= 1'b0;
            temp_pend <= 1'b0;
            state <= S_IDLE;
            cap_charge_pin <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    // Flight difference wins when both are due
                    if (sequence_running && tof_pend) begin
                        tof_pend <= 1'b0;
                        tof_left <= tof_left - 6'd1;
                        tof_tmr <= tof_period;
                        cal_for_temp <= 1'b0;
                        if (cal_config[`CAL_TOF_BIT]) begin
                            cal_start <= 1'b1;
                            state <= S_CAL;
                        end else begin
                            tof_start <= 1'b1;
                            state <= S_TOF;
                        end
                    end else if (sequence_running && temp_pend) begin
                        temp_pend <= 1'b0;
                        temp_left <= temp_left - 6'd1;
                        temp_tmr <= temp_period;
                        cal_for_temp <= 1'b1;
                        step <= 4'h0;
                        tcnt <= 13'h0;
                        t_err <= 1'b0;
                        t_fault <= 1'b0;
                        if (cal_config[`CAL_TEMP_BIT]) begin
                            cal_start <= 1'b1;
                            state <= S_CAL;
                        end else begin
                            cap_charge_pin <= 1'b1;
                            state <= S_CHG;
                        end
                    end else if (sequence_running && tof_left == 6'h0 &&
                            temp_left == 6'h0) begin
                        if (continuous_sequence) begin
                            init_seq(mode);
                        end else begin
                            sequence_running <= 1'b0;
                        end
                    end
                end
                S_CAL: begin
                    // A failed calibration keeps old coefficients and carries on
                    if (cal_done) begin
                        if (cal_for_temp) begin
                            cap_charge_pin <= 1'b1;
                            state <= S_CHG;
                        end else begin
                            tof_start <= 1'b1;
                            state <= S_TOF;
                        end
                    end
                end
                S_TOF: begin
                    if (tof_done) begin
                        if (tof_error) begin
                            flight_difference <= `DIFF_ERR;
                        end else begin
                            flight_difference <= diff;
                            tof_valid_counter <= tof_valid_counter + 8'h1;
                            difference_running_average <= difference_running_average +
                                avg_q[31:0];
                            tof_min <= new_min;
                            tof_max <= new_max;
                            tof_spread <= new_max - new_min;
                        end
                        if (per_command_irq) begin
                            ev_irq <= 1'b1;
                        end
                        if (tof_left == 6'h0) begin
                            tof_sequence_done_flag <= 1'b1;
                            ev_irq <= 1'b1;
                        end
                        state <= S_IDLE;
                    end
                end
                S_CHG: begin
                    tcnt <= tcnt + 13'h1;
                    if (tcnt == `CHARGE_CYC - 1) begin
                        cap_charge_pin <= 1'b0;
                        // A capacitor that never charged is a fault of the whole run
                        if (!comp_high) begin
                            t_fault <= 1'b1;
                            state <= S_GAP;
                        end else begin
                            state <= S_DIS;
                        end
                    end
                end
                S_DIS: begin
                    // Synchroniser latency adds a fixed few cycles to every time
                    tcnt <= tcnt + 13'h1;
                    if (!comp_high) begin
                        if (real_step) begin
                            pend[pidx] <= (meas < `SHORT_CYC) ? `RES_SHORT : {3'h0, meas};
                        end
                        if (real_step && meas < `SHORT_CYC) begin
                            t_err <= 1'b1;
                        end
                        state <= S_GAP;
                    end else if (tcnt == ivl + `OPEN_CYC) begin
                        if (real_step) begin
                            pend[pidx] <= `RES_OPEN;
                        end
                        t_err <= 1'b1;
                        timeout_flag <= 1'b1;
                        ev_irq <= 1'b1;
                        state <= S_GAP;
                    end
                end
                S_GAP: begin
                    tcnt <= tcnt + 13'h1;
                    if (tcnt >= ivl - 13'h1) begin
                        tcnt <= 13'h0;
                        if (step == last_step) begin
                            state <= S_TFIN;
                        end else begin
                            step <= step + 4'h1;
                            cap_charge_pin <= 1'b1;
                            state <= S_CHG;
                        end
                    end
                end
                S_TFIN: begin
                    tfin <= 1'b1;
                    t_bad <= t_err | t_fault;
                    temp_done_flag <= 1'b1;
                    if (!t_err && !t_fault) begin
                        temp_cycle_counter <= temp_cycle_counter + 8'h1;
                    end
                    if (per_command_irq) begin
                        ev_irq <= 1'b1;
                    end
                    if (temp_left == 6'h0) begin
                        temp_seq_done_flag <= 1'b1;
                        ev_irq <= 1'b1;
                    end
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
end

////////////////////////////////////////

// Results and averages per port; fraction is coarse so it only carries codes
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : port_res
        reg [15:0] r_int;
        reg [15:0] r_frac;
        reg [15:0] r_avg;
        wire signed [17:0] d = {2'b00, pend[g]} - {2'b00, r_avg};
        wire signed [17:0] n = {10'h0, temp_cycle_counter} + 18'h1;
        wire signed [17:0] q = d / n;
        always @(posedge mclk) begin
            if (rst) begin
                r_int <= 16'h0;
                r_frac <= 16'h0;
                r_avg <= 16'h0;
            end else if (tfin) begin
                if (t_fault) begin
                    r_int <= `RES_OPEN;
                    r_frac <= `RES_OPEN;
                end else begin
                    r_int <= pend[g];
                    r_frac <= (pend[g] == `RES_OPEN) ? `RES_OPEN : 16'h0;
                end
                if (!t_bad) begin
                    r_avg <= r_avg + q[15:0];
                end
            end else if (state == S_IDLE && start_cmd) begin
                r_avg <= 16'h0;
            end
        end
        assign port_time_integer[16*g+:16] = r_int;
        assign port_time_fraction[16*g+:16] = r_frac;
        assign temp_average_result[16*g+:16] = r_avg;
    end
endgenerate

////////////////////////////////////////

// Pin is open drain, active low; released whenever interrupts are disabled
always @(posedge mclk) begin
    if (rst) begin
        irq_pending <= 1'b0;
        irq_n <= 1'b1;
        irq_drive_n <= 1'b1;
    end else begin
        irq_pending <= ev_irq | (irq_pending & ~irq_status_read);
        irq_n <= ~irq_pending;
        irq_drive_n <= ~(irq_pending & irq_enable);
    end
end

endmodule

//--- temp_seq_monitor.sv
// Checker on the sequencer top ports.
// Assumes one clock, sync active-high reset.
`timescale 1ns/1ns
module temp_seq_monitor (
    // Clock, reset, commands and configuration
    input wire mclk, rst, auto_tof_cmd, auto_temp_cmd, auto_both_cmd, halt_cmd,
    irq_status_read, continuous_sequence,
    input wire [1:0] cal_config,
    // Flight engine and outputs watched
    input wire tof_start, tof_done, tof_error, emul_enable, tof_sequence_done_flag,
    sequence_running, irq_n, irq_drive_n,
    input wire [3:0] port_enable,
    input wire [7:0] tof_valid_counter
);
    wire start_any = auto_tof_cmd | auto_temp_cmd | auto_both_cmd;
    // Continuous restarts zero the counter
    wire ok_done = tof_done & ~tof_error & ~continuous_sequence;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_drive; !irq_drive_n |-> !irq_n; endproperty
    a_drive: assert property (p_drive) else $error("pin driven while idle");
    property p_hold;
        !irq_n && !irq_status_read && !$past(irq_status_read) |=> !irq_n;
    endproperty
    a_hold: assert property (p_hold) else $error("irq released early");
    property p_start; start_any |=> sequence_running; endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_halt; halt_cmd && !start_any |-> ##[1:2] !sequence_running; endproperty
    a_halt: assert property (p_halt) else $error("halt ignored");
    property p_tof; auto_tof_cmd && !cal_config[0] |-> ##[2:4] tof_start; endproperty
    a_tof: assert property (p_tof) else $error("no flight start");
    property p_port; $onehot0({emul_enable, port_enable}); endproperty
    a_port: assert property (p_port) else $error("two paths enabled");
    property p_keep;
        tof_done && tof_error && !continuous_sequence |=> $stable(tof_valid_counter);
    endproperty
    a_keep: assert property (p_keep) else $error("error counted");
    property p_inc; ok_done |=> tof_valid_counter == $past(tof_valid_counter) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("valid not counted");
    property p_seq; $rose(tof_sequence_done_flag) |-> ##[0:2] !irq_n; endproperty
    a_seq: assert property (p_seq) else $error("no sequence irq");
endmodule
////////////////////////////////////////
bind temp_sequencer temp_seq_monitor mon (.*);

//--- rtd_model.sv
// RTD ports and timing capacitor.
// Assumes one-hot enables; charge pin high while charging.
`timescale 1ns/1ns
module rtd_model (
    // Clock
    input wire mclk,
    // Front end
    input wire cap_charge_pin,
    input wire [3:0] port_enable,
    input wire emul_enable,
    // Forces the comparator low
    input wire stuck_low,
    output reg temp_comparator = 1'b0
);
    // Discharge cycles per port, port0 low; ffff never discharges
    parameter [63:0] DELAYS = 64'h01f4_ffff_012c_0014;
    parameter [15:0] EMUL_DELAY = 16'h012c;
    reg [15:0] t = 16'h0000;
    reg [15:0] d;
    always @* begin
        d = EMUL_DELAY;
        for (int i = 0; i < 4; i++) if (port_enable[i]) d = DELAYS[16*i +: 16];
    end
    always @(posedge mclk) begin
        t <= cap_charge_pin ? 16'h0000 : t + {15'h0, t != 16'hffff};
        temp_comparator <= !stuck_low && (cap_charge_pin || t < d || d == 16'hffff);
    end
endmodule

//--- temp_sequencer_tb_top.sv
// Sequencer bench; plays the flight engine.
// Assumes the RTD model and a short rate base.
`timescale 1ns/1ns
module temp_sequencer_tb_top;
    bit mclk, rst, auto_tof_cmd, auto_temp_cmd, auto_both_cmd, halt_cmd, irq_status_read;
    bit continuous_sequence, per_command_irq, irq_enable, rate_multiplier, tof_done;
    bit tof_error, cal_done, stuck_low;
    bit [1:0] port_select, port_cycle_interval, cal_config;
    bit [2:0] dummy_cycle_count;
    bit [3:0] diff_rate_field, temp_rate_field;
    bit [4:0] diff_count_field, temp_count_field;
    bit [31:0] upstream_average, downstream_average, last_fd;
    wire temp_comparator, cap_charge_pin, emul_enable, tof_start, cal_start, temp_done_flag;
    wire timeout_flag, tof_sequence_done_flag, temp_seq_done_flag, sequence_running;
    wire irq_n, irq_drive_n;
    wire [3:0] port_enable;
    wire [63:0] port_time_integer, port_time_fraction, temp_average_result;
    wire [31:0] flight_difference, difference_running_average, tof_spread;
    wire [7:0] tof_valid_counter, temp_cycle_counter;
    reg [31:0] dq[$], tq[$], dv[$];
    integer fails = 0, checks = 0;
    temp_sequencer #(.RATE_BASE_CYCLES(32'd2000)) DUT (.*);
    rtd_model rc (.*);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input string n, input [63:0] e, s);
        checks = checks + 1;
        if (e !== s) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Filter latency: times are checked in a window
    task check_in(input [31:0] r, input [15:0] s);
        checks = checks + 1;
        if (!((s >= r[31:16]) === 1'b1 && (s <= r[15:0]) === 1'b1)) begin
            fails = fails + 1;
            $display("Error port_time expected %h seen %h", r, s);
        end
    endtask
    task wt(input integer w, lim);
        integer n;
        n = 0;
        while (!(w == 0 ? tof_start : w == 1 ? tof_sequence_done_flag : temp_done_flag)) begin
            @(posedge mclk);
            #1 n = n + 1;
            if (n > lim) begin
                fails = fails + 1;
                $display("Error wait%0d expected 1 seen 0", w);
                print_verdict;
            end
        end
    endtask
    task go(input [2:0] c);
        @(posedge mclk);
        {auto_both_cmd, auto_temp_cmd, auto_tof_cmd} <= c;
        @(posedge mclk);
        {auto_both_cmd, auto_temp_cmd, auto_tof_cmd} <= 3'h0;
    endtask
    task answer(input bit err);
        reg [31:0] u, d;
        u = $urandom % 5000 + 1000;
        d = $urandom % 1000;
        wt(0, 3000);
        @(posedge mclk);
        {tof_done, tof_error, upstream_average, downstream_average} <= {1'b1, err, u, d};
        dq.push_back(err ? 32'h7fffffff : u - d);
        if (!err) dv.push_back(u - d);
        @(posedge mclk);
        tof_done <= 1'b0;
    endtask
    task push_temp(input bit f);
        tq.push_back(f ? '1 : 32'h0);
        tq.push_back(f ? '1 : 32'h012c0136);
        tq.push_back('1);
        tq.push_back(f ? '1 : 32'h01f401fe);
    endtask
    task ack(input string t);
        @(posedge mclk);
        irq_status_read <= 1'b1;
        @(posedge mclk);
        irq_status_read <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check("irq_clear", 1'b1, irq_n);
        $display("%s test done", t);
    endtask
    ////////////////////////////////////////
    always @(posedge mclk) begin
        #1;
        if (!rst && flight_difference !== last_fd) begin
            last_fd = flight_difference;
            check("diff", dq.pop_front(), flight_difference);
        end
    end
    always @(posedge temp_done_flag) begin
        repeat (2) @(posedge mclk);
        #1;
        for (int i = 0; i < 4; i++) check_in(tq.pop_front(), port_time_integer[16*i +: 16]);
    end
    initial begin
        rst = 1'b1;
        void'($urandom(77406));
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        irq_enable <= 1'b1;
        port_select <= 2'h3;
        dummy_cycle_count <= $urandom % 8;
        push_temp(0);
        go(3'h2);
        wt(2, 30000);
        repeat (3) @(posedge mclk);
        #1 check("timeout", 1'b1, timeout_flag);
        check("frac", 32'hffff0000, {port_time_fraction[47:32], port_time_fraction[15:0]});
        check("tcount", 8'h00, temp_cycle_counter);
        check("tavg", 64'h0, temp_average_result);
        check("irq", 2'h0, {irq_n, irq_drive_n});
        ack("temp");
        stuck_low <= 1'b1;
        port_select <= $urandom % 4;
        push_temp(1);
        go(3'h2);
        wt(2, 30000);
        ack("fault");
        stuck_low <= 1'b0;
        rate_multiplier <= 1'b1;
        diff_count_field <= 5'h2;
        per_command_irq <= 1'b1;
        go(3'h1);
        answer(0);
        repeat (4) @(posedge mclk);
        #1 check("cmd_irq", 1'b0, irq_n);
        answer(1);
        answer(0);
        wt(1, 500);
        check("valid", 8'h02, tof_valid_counter);
        check("spread", dv[0] > dv[1] ? dv[0] - dv[1] : dv[1] - dv[0], tof_spread);
        check("avg", $signed(dv[0]) + $signed(dv[1] - dv[0]) / 2, difference_running_average);
        repeat (2) @(posedge mclk);
        #1 check("run", 1'b0, sequence_running);
        ack("flight");
        continuous_sequence <= 1'b1;
        diff_count_field <= 5'h0;
        per_command_irq <= 1'b0;
        go(3'h1);
        answer(0);
        answer(0);
        @(posedge mclk);
        halt_cmd <= 1'b1;
        @(posedge mclk);
        halt_cmd <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check("halt", 1'b0, sequence_running);
        continuous_sequence <= 1'b0;
        ack("cont");
        port_select <= 2'h3;
        push_temp(0);
        go(3'h4);
        answer(0);
        wt(2, 30000);
        ack("both");
        print_verdict;
    end
endmodule
